// *** hw/fsw_cfg.svh ***
`ifndef FSW_CFG_SVH
`define FSW_CFG_SVH
// Summary of operation
// - eight-bit status word, all bits reset zero
// - protect and lock bits change only by status write
// - status readable anytime, even while busy
// - busy bit read-only, high during write cycles
// - latch clear blocks status, program, erase
// - write-enable command sets the latch
// - write-disable or finished write clears latch
// - program or erase refused inside protected region
// - full erase only with all protect bits zero
// - low codes protect top 1..16 blocks
// - high codes protect bottom 16..31 blocks
// - code 0 none, codes 6 to 9 and 15 all
// - lock set and pin low freezes status while quad enable is clear
// - lock clear or pin high allows status write
// - quad enable turns protect and hold pins into data lines 2, 3
// - 4 KB sectors, sixteen per 64 KB block
// - frames not multiple of eight clocks discarded

// ****************************************
// status word bit positions and reset
// ****************************************
`define FSW_BIT_BUSY 0
`define FSW_BIT_WEL 1
`define FSW_BIT_BP_LO 2
`define FSW_BIT_BP_HI 5
`define FSW_BIT_QE 6
`define FSW_BIT_LOCK 7
`define FSW_STATUS_RESET 8'h00

// ****************************************
// address decode
// ****************************************
`define FSW_BLOCK_HI 20
`define FSW_BLOCK_LO 16
`define FSW_SECTOR_HI 20
`define FSW_SECTOR_LO 12
`define FSW_SECTORS_PER_BLOCK_LOG2 4

// ****************************************
// command codes
// ****************************************
`define FSW_OP_WRITE_ENABLE_CMD 8'h06
`define FSW_OP_WRITE_DISABLE_CMD 8'h04
`define FSW_OP_READ_STATUS_CMD 8'h05
`define FSW_OP_WRITE_STATUS_CMD 8'h01
`define FSW_OP_PROG 8'h02
`define FSW_OP_SECT_A 8'h20
`define FSW_OP_SECT_B 8'hD7
`define FSW_OP_BLK 8'hD8
`define FSW_OP_FULL_A 8'hC7
`define FSW_OP_FULL_B 8'h60

// ****************************************
// timing
// ****************************************
`define FSW_CLK_NS 100
`define FSW_STATUS_WRITE_NS 1000
`define FSW_STATUS_WRITE_CYC ((`FSW_STATUS_WRITE_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)

`endif

// *** hw/fsw_pkg.sv ***
package fsw_pkg;

    // kind of array operation handed to the array engine
    typedef enum logic [1:0] {
        FSW_KIND_PROGRAM = 2'h0,
        FSW_KIND_SECTOR = 2'h1,
        FSW_KIND_BLOCK = 2'h2,
        FSW_KIND_FULL = 2'h3
    } fsw_kind_t;

    // one-cycle launch of an array operation
    typedef struct packed {
        logic valid;
        fsw_kind_t kind;
        logic [20:0] addr;
    } fsw_op_t;

    // status word, msb first
    typedef struct packed {
        logic status_lock;
        logic quad_lines_enable;
        logic [3:0] block_protect_code;
        logic write_enable_latch;
        logic busy_flag;
    } fsw_status_t;

    // write cycle tracker
    typedef enum logic [2:0] {
        FSW_IDLE = 3'b001,
        FSW_ARRAY = 3'b010,
        FSW_STWR = 3'b100
    } fsw_state_t;

endpackage

// *** hw/fsw_status_protect.sv ***
`timescale 1ns/1ps
`include "fsw_cfg.svh"

module fsw_status_protect (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_oe,
    input wire logic data_line_2_in,
    output logic data_line_2_out,
    output logic data_line_2_oe,
    input wire logic data_line_3_in,
    output logic data_line_3_out,
    output logic data_line_3_oe,
    output fsw_pkg::fsw_op_t array_op,
    input wire logic array_done,
    output fsw_pkg::fsw_status_t status_word,
    output logic quad_mode
);

    // ****************************************
    // helpers
    // ****************************************

    // true when a block falls inside the region of a protect code
    function automatic logic block_protected(input logic [3:0] code, input logic [4:0] blk);
        logic hit;
        hit = 1'b1;
        case (code)
            4'h0: hit = 1'b0;
            4'h1: hit = (blk >= 5'h1F);
            4'h2: hit = (blk >= 5'h1E);
            4'h3: hit = (blk >= 5'h1C);
            4'h4: hit = (blk >= 5'h18);
            4'h5: hit = (blk >= 5'h10);
            4'hA: hit = (blk < 5'h10);
            4'hB: hit = (blk < 5'h18);
            4'hC: hit = (blk < 5'h1C);
            4'hD: hit = (blk < 5'h1E);
            4'hE: hit = (blk < 5'h1F);
            default: hit = 1'b1; // codes 6,7,8,9,15 cover all
        endcase
        return hit;
    endfunction

    // block of a byte address, through its sector index
    function automatic logic [4:0] block_of(input logic [20:0] addr);
        logic [8:0] sector;
        sector = addr[`FSW_SECTOR_HI:`FSW_SECTOR_LO];
        return sector[8:`FSW_SECTORS_PER_BLOCK_LOG2];
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************

    // order: sck, cs_n, si, protect pin, hold pin
    logic [4:0] sync1_q; // first stage, read only by second
    logic [4:0] sync2_q; // safe copies
    logic sck_s;
    logic cs_n_s;
    logic si_s;
    logic wp_n_s;
    logic hold_n_s;

    // two flops per pin, the link clock is just a sampled input
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sync1_q <= 5'h1F;
            sync2_q <= 5'h1F;
        end else if (clk_en) begin
            sync1_q <= {data_line_3_in, data_line_2_in, spi_si, spi_cs_n, spi_sck};
            sync2_q <= sync1_q;
        end
    end

    assign sck_s = sync2_q[0];
    assign cs_n_s = sync2_q[1];
    assign si_s = sync2_q[2];
    assign wp_n_s = sync2_q[3];
    assign hold_n_s = sync2_q[4];

    // ****************************************
    // serial frame capture
    // ****************************************

    logic sck_prev_q, sck_prev_d; // last sampled clock level
    logic cs_prev_q, cs_prev_d; // last sampled select level
    logic [2:0] bit_cnt_q, bit_cnt_d; // bits in current byte
    logic [2:0] byte_cnt_q, byte_cnt_d; // whole bytes, saturates at 7
    logic [7:0] shift_q, shift_d; // incoming byte
    logic [7:0] opcode_q, opcode_d; // first byte of frame
    logic [23:0] addr_q, addr_d; // bytes two to four
    logic [7:0] wdata_q, wdata_d; // second byte, status data
    logic [7:0] out_shift_q, out_shift_d; // outgoing status bits
    logic so_q, so_d;
    logic so_oe_q, so_oe_d;
    logic rise;
    logic fall;
    logic frame_end;
    logic frame_whole;
    logic paused;
    fsw_pkg::fsw_status_t status_q, status_d;

    // hold only exists while the pins are not data lines
    assign paused = !status_q.quad_lines_enable && !hold_n_s;
    assign rise = sck_s && !sck_prev_q && !cs_n_s && !paused;
    assign fall = !sck_s && sck_prev_q && !cs_n_s && !paused;
    assign frame_end = cs_n_s && !cs_prev_q;
    // partial bytes kill the whole frame
    assign frame_whole = (bit_cnt_q == 3'h0);

    // next values of the serial shifter
    always_comb begin
        sck_prev_d = sck_s;
        cs_prev_d = cs_n_s;
        bit_cnt_d = bit_cnt_q;
        byte_cnt_d = byte_cnt_q;
        shift_d = shift_q;
        opcode_d = opcode_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        out_shift_d = out_shift_q;
        so_d = so_q;
        so_oe_d = so_oe_q;
        if (cs_n_s) begin
            // deselected: counters ready for next frame, output released
            bit_cnt_d = 3'h0;
            byte_cnt_d = 3'h0;
            so_oe_d = 1'b0;
        end else begin
            if (rise) begin
                shift_d = {shift_q[6:0], si_s};
                bit_cnt_d = 3'(bit_cnt_q + 3'h1);
                if (bit_cnt_q == 3'h7) begin
                    if (byte_cnt_q != 3'h7) begin
                        byte_cnt_d = 3'(byte_cnt_q + 3'h1);
                    end
                    if (byte_cnt_q == 3'h0) begin
                        opcode_d = shift_d;
                    end else if (byte_cnt_q <= 3'h3) begin
                        addr_d = {addr_q[15:0], shift_d};
                    end
                    if (byte_cnt_q == 3'h1) begin
                        wdata_d = shift_d;
                    end
                end
            end
            // status streams out, reloaded live at each byte start
            if (fall && byte_cnt_q != 3'h0 && opcode_q == `FSW_OP_READ_STATUS_CMD) begin
                so_oe_d = 1'b1;
                if (bit_cnt_q == 3'h0) begin
                    so_d = status_q[7];
                    out_shift_d = {status_q[6:0], 1'b0};
                end else begin
                    so_d = out_shift_q[7];
                    out_shift_d = {out_shift_q[6:0], 1'b0};
                end
            end
        end
    end

    // registers of the serial shifter
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
            wdata_q <= 8'h00;
            out_shift_q <= 8'h00;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else if (clk_en) begin
            sck_prev_q <= sck_prev_d;
            cs_prev_q <= cs_prev_d;
            bit_cnt_q <= bit_cnt_d;
            byte_cnt_q <= byte_cnt_d;
            shift_q <= shift_d;
            opcode_q <= opcode_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            out_shift_q <= out_shift_d;
            so_q <= so_d;
            so_oe_q <= so_oe_d;
        end
    end

    // ****************************************
    // status word and write control
    // ****************************************

    fsw_pkg::fsw_state_t state_q, state_d;
    logic [7:0] wait_q, wait_d; // status write cycle countdown
    fsw_pkg::fsw_op_t op_q, op_d;
    logic locked; // status frozen by lock and pin
    logic target_prot; // addressed block protected
    logic is_erase_sect;
    logic is_full;

    // with quad enable the protect pin is a data line, so it cannot freeze status
    assign locked = status_q.status_lock && !wp_n_s && !status_q.quad_lines_enable;
    assign target_prot = block_protected(status_q.block_protect_code, block_of(addr_q[20:0]));
    assign is_erase_sect = (opcode_q == `FSW_OP_SECT_A) || (opcode_q == `FSW_OP_SECT_B);
    assign is_full = (opcode_q == `FSW_OP_FULL_A) || (opcode_q == `FSW_OP_FULL_B);

    // next status, state and array launch
    always_comb begin
        status_d = status_q;
        state_d = state_q;
        wait_d = wait_q;
        op_d = op_q;
        op_d.valid = 1'b0;
        // completion first, so a write-enable in the same cycle wins
        case (state_q)
            fsw_pkg::FSW_IDLE: begin
                wait_d = 8'h00;
            end
            fsw_pkg::FSW_ARRAY: begin
                if (array_done) begin
                    state_d = fsw_pkg::FSW_IDLE;
                    status_d.write_enable_latch = 1'b0;
                end
            end
            fsw_pkg::FSW_STWR: begin
                wait_d = 8'(wait_q - 8'h01);
                if (wait_q == 8'h01) begin
                    state_d = fsw_pkg::FSW_IDLE;
                    status_d.write_enable_latch = 1'b0;
                end
            end
            default: begin
                state_d = fsw_pkg::FSW_IDLE;
            end
        endcase
        if (frame_end && frame_whole) begin
            case (opcode_q)
                `FSW_OP_WRITE_ENABLE_CMD: begin
                    if (byte_cnt_q == 3'h1) begin
                        status_d.write_enable_latch = 1'b1;
                    end
                end
                `FSW_OP_WRITE_DISABLE_CMD: begin
                    if (byte_cnt_q == 3'h1) begin
                        status_d.write_enable_latch = 1'b0;
                    end
                end
                `FSW_OP_WRITE_STATUS_CMD: begin
                    // needs latch, idle, unlocked; only here do nv bits change
                    if (byte_cnt_q >= 3'h2 && status_q.write_enable_latch && state_q == fsw_pkg::FSW_IDLE
                            && !locked) begin
                        status_d.status_lock = wdata_q[`FSW_BIT_LOCK];
                        status_d.quad_lines_enable = wdata_q[`FSW_BIT_QE];
                        status_d.block_protect_code = wdata_q[`FSW_BIT_BP_HI:`FSW_BIT_BP_LO];
                        state_d = fsw_pkg::FSW_STWR;
                        wait_d = 8'(`FSW_STATUS_WRITE_CYC);
                    end
                end
                default: begin
                    if (status_q.write_enable_latch && state_q == fsw_pkg::FSW_IDLE) begin
                        if (is_full && byte_cnt_q == 3'h1 && status_q.block_protect_code == 4'h0) begin
                            op_d.valid = 1'b1;
                            op_d.kind = fsw_pkg::FSW_KIND_FULL;
                            op_d.addr = 21'h000000;
                            state_d = fsw_pkg::FSW_ARRAY;
                        end else if (byte_cnt_q >= 3'h4 && !target_prot
                                && (opcode_q == `FSW_OP_PROG || opcode_q == `FSW_OP_BLK || is_erase_sect)) begin
                            op_d.valid = 1'b1;
                            op_d.kind = (opcode_q == `FSW_OP_PROG) ? fsw_pkg::FSW_KIND_PROGRAM :
                                        (opcode_q == `FSW_OP_BLK) ? fsw_pkg::FSW_KIND_BLOCK : fsw_pkg::FSW_KIND_SECTOR;
                            op_d.addr = addr_q[20:0];
                            state_d = fsw_pkg::FSW_ARRAY;
                        end
                    end
                end
            endcase
        end
        // busy mirrors the write cycle tracker, never written directly
        status_d.busy_flag = (state_d != fsw_pkg::FSW_IDLE);
    end

    // registers of status and control
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            status_q <= `FSW_STATUS_RESET;
            state_q <= fsw_pkg::FSW_IDLE;
            wait_q <= 8'h00;
            op_q <= '0;
        end else if (clk_en) begin
            status_q <= status_d;
            state_q <= state_d;
            wait_q <= wait_d;
            op_q <= op_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    // quad data paths live outside this block, so these lines stay undriven here
    logic quad_q;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            quad_q <= 1'b0;
        end else if (clk_en) begin
            quad_q <= status_d.quad_lines_enable;
        end
    end

    assign spi_so = so_q;
    assign spi_so_oe = so_oe_q;
    assign data_line_2_out = 1'b0;
    assign data_line_2_oe = 1'b0;
    assign data_line_3_out = 1'b0;
    assign data_line_3_oe = 1'b0;
    assign array_op = op_q;
    assign status_word = status_q;
    assign quad_mode = quad_q;

endmodule

// *** tb/fsw_props.sv ***
`timescale 1ns/1ps
// ****
// port watcher for the status and protect block
// ****
module fsw_props (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic spi_cs_n,
    input wire logic spi_so_oe,
    input wire logic data_line_2_in,
    input wire fsw_pkg::fsw_op_t array_op,
    input wire logic array_done,
    input wire fsw_pkg::fsw_status_t status_word,
    input wire logic quad_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_op_launch: assert property (
        array_op.valid |-> (status_word.busy_flag && status_word.write_enable_latch) ##1 !array_op.valid)
        else $error("launch without latch or longer than one cycle");
    a_full_unprot: assert property (
        array_op.valid && array_op.kind == fsw_pkg::FSW_KIND_FULL |-> status_word.block_protect_code == 4'h0)
        else $error("full erase launched with protect bits set");
    a_op_idle: assert property (
        array_op.valid |-> !$past(status_word.busy_flag)) else $error("launch while busy");
    a_done_clears: assert property (
        status_word.busy_flag && array_done |=> !status_word.busy_flag && !status_word.write_enable_latch)
        else $error("done did not clear busy and latch");
    // status write: ten busy cycles, then busy and latch drop together
    a_stwr_time: assert property (
        $rose(status_word.busy_flag) && !array_op.valid |-> status_word.busy_flag [*8] ##1 status_word.busy_flag
        ##1 status_word.busy_flag ##1 (!status_word.busy_flag && !status_word.write_enable_latch))
        else $error("status write busy time wrong");
    a_stwr_wel: assert property (
        $rose(status_word.busy_flag) && !array_op.valid |-> $past(status_word.write_enable_latch))
        else $error("status write without latch");
    a_prot_write: assert property (
        !$stable({status_word.status_lock, status_word.quad_lines_enable, status_word.block_protect_code})
        |-> $rose(status_word.busy_flag) && !array_op.valid) else $error("protect bits moved outside status write");
    // wp held low for a while so the synchroniser has caught up
    a_lock_freeze: assert property (
        status_word.status_lock && !status_word.quad_lines_enable && !data_line_2_in && !$past(data_line_2_in, 4)
        |=> $stable({status_word.status_lock, status_word.block_protect_code})) else $error("locked bits changed");
    a_quad_copy: assert property (quad_mode == status_word.quad_lines_enable)
        else $error("quad mode differs from enable bit");
    a_so_quiet: assert property (spi_cs_n [*5] |-> !spi_so_oe)
        else $error("output driven while deselected");

    c_launch: cover property (array_op.valid);
    c_stwr: cover property ($rose(status_word.busy_flag) && !array_op.valid);
    c_read: cover property (spi_so_oe);
    c_lock: cover property (status_word.status_lock && !data_line_2_in);
endmodule

// *** tb/fsw_spi_master.sv ***
`timescale 1ns/1ps
// ****
// serial master model, mode 0, 800 ns clock
// ****
module fsw_spi_master (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    logic [7:0] rx_q; // bytes read back from the device
    // idle: deselected, clock parked low
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx_q = 8'h00;
    end
    // nb bits of d msb first, then nr bytes read; nb off eight only on request
    task automatic xfer(input logic [31:0] d, input int nb, input int nr);
        cs_n = 1'b0;
        for (int i = nb - 1 + 8 * nr; i >= 0; i--) begin
            // data line toggles once our bits are spent, never a stale copy
            si = (i >= 8 * nr) ? d[i - 8 * nr] : ~si;
            #400 sck = 1'b1;
            rx_q = {rx_q[6:0], so};
            #400 sck = 1'b0;
        end
        #400 cs_n = 1'b1;
        #800;
    endtask
endmodule

// *** tb/tb_flash_status_write_protect.sv ***
`timescale 1ns/1ps
// ****
// bench top
// ****
module tb_flash_status_write_protect;
    logic ref_clk, reset_n, wp, hold, done; // clock, reset, protect pin, hold pin, engine done
    logic sck, cs_n, si, so, so_oe; // serial link
    logic so_pin; // output line as the master sees it
    fsw_pkg::fsw_op_t op; // array launch
    fsw_pkg::fsw_status_t st; // status word
    logic quad; // pin mode
    logic [1:0] kind; // kind of last launch
    logic [20:0] op_addr; // address of last launch
    int errors = 0, cmp_count = 0, n_ops = 0; // tallies
    // rows: protect code beside the block mask it should protect
    logic [35:0] rows [16] = '{36'h0_0000_0000, 36'h1_8000_0000, 36'h2_C000_0000, 36'h3_F000_0000,
        36'h4_FF00_0000, 36'h5_FFFF_0000, 36'h6_FFFF_FFFF, 36'h7_FFFF_FFFF, 36'h8_FFFF_FFFF,
        36'h9_FFFF_FFFF, 36'hA_0000_FFFF, 36'hB_00FF_FFFF, 36'hC_0FFF_FFFF, 36'hD_3FFF_FFFF,
        36'hE_7FFF_FFFF, 36'hF_FFFF_FFFF};
    int blks [9] = '{15, 16, 23, 24, 27, 28, 29, 30, 31}; // blocks on region edges
    logic [7:0] opc [6] = '{8'h02, 8'h20, 8'hD7, 8'hD8, 8'hC7, 8'h60}; // write commands
    logic [1:0] kinds [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3}; // kind each should launch

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    fsw_status_protect DUT (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1), .spi_sck(sck), .spi_cs_n(cs_n),
        .spi_si(si), .spi_so(so), .spi_so_oe(so_oe), .data_line_2_in(wp), .data_line_2_out(), .data_line_2_oe(),
        .data_line_3_in(hold), .data_line_3_out(), .data_line_3_oe(), .array_op(op), .array_done(done),
        .status_word(st), .quad_mode(quad));
    // released line reads as the inverse, so a late enable cannot hide behind a stale bit
    assign so_pin = so_oe ? so : ~so;
    fsw_spi_master m (.sck(sck), .cs_n(cs_n), .si(si), .so(so_pin));

    // count launches as they pass
    always @(posedge ref_clk) begin
        if (op.valid === 1'b1) begin
            n_ops <= n_ops + 1;
            kind <= op.kind;
            op_addr <= op.addr;
        end
    end

    // ****
    // helpers
    // ****
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmd(input logic [31:0] d, input int nb, input int nr);
        @(posedge ref_clk);
        #1 m.xfer(d, nb, nr);
    endtask
    // engine completion pulse, then busy and latch must be down
    task automatic finish_op();
        @(posedge ref_clk);
        #1 done = 1'b1;
        @(posedge ref_clk);
        #1 done = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("busy_wel", st[1:0], 2'h0);
    endtask
    task automatic wr_status(input logic [7:0] v);
        cmd(32'h06, 8, 0);
        cmd({16'h0, 8'h01, v}, 16, 0);
        repeat (12) @(posedge ref_clk);
        #1;
    endtask
    task automatic try_op(input int i, input logic [20:0] a, input logic go);
        int n0;
        n0 = n_ops;
        cmd(32'h06, 8, 0);
        if (i >= 4) cmd({24'h0, opc[i]}, 8, 0);
        else cmd({opc[i], 3'h0, a}, 32, 0);
        check("launch", n_ops - n0, go);
        if (go) begin
            check("kind", kind, kinds[i]);
            check("addr", op_addr, (i >= 4) ? 21'h0 : a);
            finish_op();
        end else begin
            check("kept_wel", st[1:0], 2'h2);
        end
    endtask

    // watchdog
    initial begin
        #8_000_000;
        errors++;
        stop_test();
    end

    // ****
    // tests
    // ****
    initial begin
        reset_n = 1'b0;
        wp = 1'b1;
        hold = 1'b1;
        done = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        check("reset", st, 8'h00);
        $display("test reset done");
        foreach (rows[r]) begin
            wr_status({2'h0, rows[r][35:32], 2'h0});
            check("status", st, {2'h0, rows[r][35:32], 2'h0});
            foreach (blks[b]) try_op(b % 4, {blks[b][4:0], 16'hF123}, ~rows[r][blks[b]]);
        end
        for (int i = 4; i < 6; i++) try_op(i, 21'h0, 1'b0);
        wr_status(8'h00);
        for (int i = 4; i < 6; i++) try_op(i, 21'h0, 1'b1);
        $display("test protect map done");
        cmd(32'h013C, 16, 0);
        repeat (12) @(posedge ref_clk);
        #1;
        check("no_wel", st, 8'h00);
        cmd(32'h06, 8, 0);
        check("wel_set", st, 8'h02);
        // whole status write plus one stray bit, would set all protect bits if taken
        cmd(32'h0278, 17, 0);
        repeat (12) @(posedge ref_clk);
        #1;
        check("partial", st, 8'h02);
        cmd(32'h04, 8, 0);
        check("wel_clr", st, 8'h00);
        // hold low for a whole frame: no clock edge counts, latch stays clear
        hold = 1'b0;
        cmd(32'h06, 8, 0);
        check("hold_qe0", st, 8'h00);
        hold = 1'b1;
        $display("test latch done");
        cmd(32'h06, 8, 0);
        cmd(32'hD8000000, 32, 0);
        cmd(32'h06, 8, 0);
        cmd(32'h013C, 16, 0);
        cmd(32'h05, 8, 1);
        check("rd_busy", m.rx_q, 8'h03);
        finish_op();
        check("after_busy", st, 8'h00);
        $display("test busy done");
        wp = 1'b0;
        wr_status(8'h84);
        check("lock_set", st, 8'h84);
        wr_status(8'h00);
        check("lock_hold", st, 8'h86);
        wp = 1'b1;
        // pins are driven here, never tied, so quad enable is safe
        wr_status(8'h40);
        check("wp_high", st, 8'h40);
        check("quad", quad, 1'b1);
        // with quad lines on, the hold pin is a data line and pauses nothing
        hold = 1'b0;
        cmd(32'h06, 8, 0);
        check("hold_qe1", st, 8'h42);
        hold = 1'b1;
        $display("test lock done");
        reset_n = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        check("reset2", {quad, st}, 9'h000);
        $display("test second reset done");
        stop_test();
    end
endmodule

bind fsw_status_protect fsw_props u_props (.ref_clk, .reset_n, .spi_cs_n, .spi_so_oe, .data_line_2_in, .array_op,
    .array_done, .status_word, .quad_mode);
